// >>> rtl/pzc_regs.svh
// Constants for the position zone comparator bank
`ifndef PZC_REGS_SVH
`define PZC_REGS_SVH

`define PZC_ZONES      7
`define PZC_POS_W      32
`define PZC_EXT_W      34
`define PZC_FLD_POS    2'h0
`define PZC_FLD_NEG    2'h1
`define PZC_FLD_MODE   2'h2
`define PZC_FLD_SRC    2'h3
`define PZC_RST_BOUND  32'h0000_0000
`define PZC_RST_MODE   1'h0
`define PZC_RST_SRC    1'h0
`define PZC_MODE_ABS   1'h0
`define PZC_MODE_OFS   1'h1
`define PZC_SRC_FB     1'h0
`define PZC_SRC_CMD    1'h1

`endif

// >>> rtl/pzc_pkg.sv
// Types shared by the position zone comparator bank
package pzc_pkg;
  typedef logic signed [31:0] pzc_pos_t;
  typedef logic signed [33:0] pzc_ext_t;
  typedef enum logic [1:0] {
    PZC_FIELD_POS  = 2'h0,
    PZC_FIELD_NEG  = 2'h1,
    PZC_FIELD_MODE = 2'h2,
    PZC_FIELD_SRC  = 2'h3
  } pzc_field_t;
endpackage : pzc_pkg

// >>> rtl/pzc_top.sv
// Seven position zone comparators with their settings store
// Notes
// Zone code 0 writes are dropped; that zone lives elsewhere.
// Limits are worked out in 34 bits, so offset plus width never wraps.
// Outputs are registered: one cycle of latency traded for clean pins.
// Positions are same-clock inputs, so they reach the comparators without a synchroniser.
`timescale 1ns/1ps
`include "pzc_regs.svh"

module pzc_top (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              cfg_wr,
  input  wire logic [2:0]        cfg_zone,
  input  wire pzc_pkg::pzc_field_t cfg_field,
  input  wire logic [31:0]       cfg_wdata,
  input  wire pzc_pkg::pzc_pos_t fb_pos,
  input  wire pzc_pkg::pzc_pos_t cmd_pos,
  input  wire pzc_pkg::pzc_pos_t tgt_pos,
  output logic                   zone_out_1,
  output logic                   zone_out_2,
  output logic                   zone_out_3,
  output logic                   zone_out_4,
  output logic                   zone_out_5,
  output logic                   zone_out_6,
  output logic                   zone_out_7
);

  pzc_pkg::pzc_pos_t pos_bnd_r [`PZC_ZONES];
  pzc_pkg::pzc_pos_t neg_bnd_r [`PZC_ZONES];
  logic              mode_r    [`PZC_ZONES];
  logic              src_r     [`PZC_ZONES];
  logic [6:0]        hit_nxt;
  logic [6:0]        hit_r;
  logic [2:0]        wr_idx;
  logic              wr_ok;

  // Zone 1..7 map to index 0..6; zone code 0 is not stored here
  assign wr_idx = cfg_zone - 3'h1;
  assign wr_ok  = cfg_wr && (cfg_zone != 3'h0);

  // Sign-extend so that offset sums and widths cannot wrap
  function automatic pzc_pkg::pzc_ext_t ext(input pzc_pkg::pzc_pos_t v);
    ext = {{2{v[31]}}, v};
  endfunction : ext

  // Range check for one zone, in 34 bits to keep extreme bounds exact
  function automatic logic zone_hit(
    input pzc_pkg::pzc_pos_t pb,
    input pzc_pkg::pzc_pos_t nb,
    input logic              md,
    input pzc_pkg::pzc_pos_t tg,
    input pzc_pkg::pzc_pos_t cur
  );
    pzc_pkg::pzc_ext_t a;
    pzc_pkg::pzc_ext_t b;
    pzc_pkg::pzc_ext_t o;
    pzc_pkg::pzc_ext_t lo;
    pzc_pkg::pzc_ext_t hi;
    o = ext(tg) + ext(pb);
    if (md == `PZC_MODE_OFS) begin
      a = o - ext(nb);
      b = o + ext(nb);
    end else begin
      a = ext(pb);
      b = ext(nb);
    end
    // Reversed bounds are ordered rather than treated as empty
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    zone_hit = (ext(cur) >= lo) && (ext(cur) <= hi);
  endfunction : zone_hit

  // Settings store, one word or bit per write
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `PZC_ZONES; i++) begin
        pos_bnd_r[i] <= `PZC_RST_BOUND;
        neg_bnd_r[i] <= `PZC_RST_BOUND;
        mode_r[i]    <= `PZC_RST_MODE;
        src_r[i]     <= `PZC_RST_SRC;
      end
    end else if (wr_ok) begin
      unique case (cfg_field)
        pzc_pkg::PZC_FIELD_POS:  pos_bnd_r[wr_idx] <= cfg_wdata;
        pzc_pkg::PZC_FIELD_NEG:  neg_bnd_r[wr_idx] <= cfg_wdata;
        pzc_pkg::PZC_FIELD_MODE: mode_r[wr_idx]    <= cfg_wdata[0];
        pzc_pkg::PZC_FIELD_SRC:  src_r[wr_idx]     <= cfg_wdata[0];
      endcase
    end
  end

  // Comparators, one per zone
  for (genvar z = 0; z < `PZC_ZONES; z++) begin : g_zone
    always_comb begin
      hit_nxt[z] = zone_hit(pos_bnd_r[z], neg_bnd_r[z], mode_r[z], tgt_pos,
                            (src_r[z] == `PZC_SRC_CMD) ? cmd_pos : fb_pos);
    end
  end

  // Registered outputs; one cycle after the position sample
  // The flop keeps the wide comparator path off the output pins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hit_r <= 7'h00;
    end else begin
      hit_r <= hit_nxt;
    end
  end

  assign zone_out_1 = hit_r[0];
  assign zone_out_2 = hit_r[1];
  assign zone_out_3 = hit_r[2];
  assign zone_out_4 = hit_r[3];
  assign zone_out_5 = hit_r[4];
  assign zone_out_6 = hit_r[5];
  assign zone_out_7 = hit_r[6];

  // Helper views of zone 1 for the checks below
  pzc_pkg::pzc_ext_t z1_lo;
  pzc_pkg::pzc_ext_t z1_hi;
  pzc_pkg::pzc_ext_t z1_o;
  always_comb begin
    z1_o  = ext(tgt_pos) + ext(pos_bnd_r[0]);
    z1_lo = (mode_r[0] ? z1_o - ext(neg_bnd_r[0]) : ext(neg_bnd_r[0]));
    z1_hi = (mode_r[0] ? z1_o + ext(neg_bnd_r[0]) : ext(pos_bnd_r[0]));
  end

  // Range checks, the zone code 0 check and all covers but cov_zone0_write watch zone 1 only, while the four field write checks take any zone;
  // the other six zones are the same comparator and are judged by the bench
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  chk_bound_write: assert property (
    wr_ok && cfg_field == pzc_pkg::PZC_FIELD_POS
    |=> pos_bnd_r[$past(wr_idx)] == $past(cfg_wdata))
    else $error("positive bound not stored");
  chk_neg_write: assert property (
    wr_ok && cfg_field == pzc_pkg::PZC_FIELD_NEG
    |=> neg_bnd_r[$past(wr_idx)] == $past(cfg_wdata))
    else $error("negative bound not stored");
  chk_abs_inside: assert property (
    !mode_r[0] && !src_r[0] && pos_bnd_r[0] >= neg_bnd_r[0]
    && fb_pos <= pos_bnd_r[0] && fb_pos >= neg_bnd_r[0] |=> zone_out_1)
    else $error("absolute zone missed inside position");
  chk_ofs_outside: assert property (
    mode_r[0] && !src_r[0] && ext(fb_pos) > z1_o + ext(neg_bnd_r[0])
    && ext(fb_pos) > z1_o - ext(neg_bnd_r[0]) |=> !zone_out_1)
    else $error("offset zone set beyond extent");
  chk_ofs_center: assert property (
    mode_r[0] && !src_r[0] && ext(fb_pos) == z1_o |=> zone_out_1)
    else $error("offset zone missed its centre");
  chk_src_fb: assert property (
    !src_r[0] && $stable(pos_bnd_r[0]) && ext(fb_pos) < z1_lo && ext(fb_pos) < z1_hi
    |=> !zone_out_1)
    else $error("feedback source not used");
  chk_src_cmd: assert property (
    src_r[0] && !mode_r[0] && cmd_pos == pos_bnd_r[0] |=> zone_out_1)
    else $error("command source not used");
  chk_order_swap: assert property (
    !mode_r[0] && src_r[0] && cmd_pos == neg_bnd_r[0] |=> zone_out_1)
    else $error("limit not inclusive");

  // Settings bits land in the addressed zone one edge after the write
  chk_mode_write: assert property (
    wr_ok && cfg_field == pzc_pkg::PZC_FIELD_MODE
    |=> mode_r[$past(wr_idx)] == $past(cfg_wdata[0]))
    else $error("range mode not stored");
  chk_src_write: assert property (
    wr_ok && cfg_field == pzc_pkg::PZC_FIELD_SRC
    |=> src_r[$past(wr_idx)] == $past(cfg_wdata[0]))
    else $error("position source not stored");

  // Zone code 0 belongs to another block; a write there must not leak
  chk_zone0_ignored: assert property (
    cfg_wr && cfg_zone == 3'h0
    |=> $stable(pos_bnd_r[0]) && $stable(neg_bnd_r[0])
    && $stable(mode_r[0]) && $stable(src_r[0]))
    else $error("zone code 0 write changed zone 1");

  // Above both absolute limits the zone must stay off
  chk_abs_above: assert property (
    !mode_r[0] && !src_r[0] && fb_pos > pos_bnd_r[0] && fb_pos > neg_bnd_r[0]
    |=> !zone_out_1)
    else $error("absolute zone set above limits");

  // The far end of the offset extent is still inside
  chk_ofs_edge: assert property (
    mode_r[0] && !src_r[0] && ext(fb_pos) == z1_o + ext(neg_bnd_r[0]) |=> zone_out_1)
    else $error("offset extent end not inclusive");

  // Below the near end of the offset extent the zone stays off
  chk_ofs_below: assert property (
    mode_r[0] && !src_r[0] && ext(fb_pos) < z1_o - ext(neg_bnd_r[0])
    && ext(fb_pos) < z1_o + ext(neg_bnd_r[0]) |=> !zone_out_1)
    else $error("offset zone set below extent");

  // Command source above both limits keeps the zone off
  chk_cmd_above: assert property (
    src_r[0] && !mode_r[0] && cmd_pos > pos_bnd_r[0] && cmd_pos > neg_bnd_r[0]
    |=> !zone_out_1)
    else $error("command zone set above limits");

  cov_abs_hit: cover property (!mode_r[0] ##1 zone_out_1);
  cov_ofs_hit: cover property (mode_r[0] ##1 zone_out_1);
  cov_cmd_hit: cover property (src_r[0] ##1 $rose(zone_out_1));

  // Reversed bounds and dropped zone 0 writes
  cov_rev_bounds: cover property (!mode_r[0] && pos_bnd_r[0] < neg_bnd_r[0] ##1 zone_out_1);
  cov_zone0_write: cover property (cfg_wr && cfg_zone == 3'h0);

endmodule : pzc_top

// >>> bench/pzc_src_model.sv
// Model of the motion profile and encoder position sources
`timescale 1ns/1ps
module pzc_src_model (
  input  wire logic              ref_clk,
  input  wire pzc_pkg::pzc_pos_t fb_set,
  input  wire pzc_pkg::pzc_pos_t cmd_set,
  input  wire pzc_pkg::pzc_pos_t tgt_set,
  output pzc_pkg::pzc_pos_t      fb_pos,
  output pzc_pkg::pzc_pos_t      cmd_pos,
  output pzc_pkg::pzc_pos_t      tgt_pos
);
  // Move away from the sampling edge, so no race with the block
  always_ff @(negedge ref_clk) begin
    fb_pos  <= fb_set;
    cmd_pos <= cmd_set;
    tgt_pos <= tgt_set;
  end
endmodule : pzc_src_model

// >>> bench/position_zone_comparators_tb.sv
// Testbench for the position zone comparator bank
`timescale 1ns/1ps
module position_zone_comparators_tb;
  logic                ref_clk = 1'b0;
  logic                resetn  = 1'b0;
  logic                cfg_wr  = 1'b0;
  logic [2:0]          cfg_zone = 3'h0;
  pzc_pkg::pzc_field_t cfg_field = pzc_pkg::PZC_FIELD_POS;
  logic [31:0]         cfg_wdata = 32'h0;
  pzc_pkg::pzc_pos_t   fb_set = '0, cmd_set = '0, tgt_set = '0, fb_pos, cmd_pos, tgt_pos;
  logic [7:1]          z;
  int                  bad_count = 0;
  int                  checked = 0;
  // Free-running 200 MHz clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  pzc_src_model src (.ref_clk(ref_clk), .fb_set(fb_set), .cmd_set(cmd_set), .tgt_set(tgt_set),
    .fb_pos(fb_pos), .cmd_pos(cmd_pos), .tgt_pos(tgt_pos));
  pzc_top dut (.ref_clk(ref_clk), .resetn(resetn), .cfg_wr(cfg_wr), .cfg_zone(cfg_zone),
    .cfg_field(cfg_field), .cfg_wdata(cfg_wdata), .fb_pos(fb_pos), .cmd_pos(cmd_pos),
    .tgt_pos(tgt_pos), .zone_out_1(z[1]), .zone_out_2(z[2]), .zone_out_3(z[3]),
    .zone_out_4(z[4]), .zone_out_5(z[5]), .zone_out_6(z[6]), .zone_out_7(z[7]));
  // One-cycle write pulse, lowered a full cycle before the next write
  task automatic wr(input logic [2:0] zn, input pzc_pkg::pzc_field_t f, input logic [31:0] d);
    @(negedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_zone <= zn;
    cfg_field <= f;
    cfg_wdata <= d;
    @(negedge ref_clk);
    cfg_wr <= 1'b0;
  endtask : wr
  // Model delay plus sample and output edges: four falling edges
  task automatic chk(input int k, input logic [31:0] f, c, t, input logic e);
    fb_set <= f;
    cmd_set <= c;
    tgt_set <= t;
    repeat (4) @(negedge ref_clk);
    checked++;
    if (z[k] !== e) begin
      bad_count++;
      $display("[ERR] zone_out_%0d pos %0h: expected %b seen %b", k, f, e, z[k]);
    end
  endtask : chk
  task automatic t_reset();
    for (int k = 1; k < 8; k++) chk(k, 32'h0, 32'h5, 32'h0, 1'b1);
    chk(4, 32'h1, 32'h0, 32'h0, 1'b0);
  endtask : t_reset
  // Reversed bounds, then the full signed span
  task automatic t_abs();
    wr(3, pzc_pkg::PZC_FIELD_POS, 32'hFFFF_FFCE);
    wr(3, pzc_pkg::PZC_FIELD_NEG, 32'h64);
    chk(3, 32'h64, 32'h0, 32'h0, 1'b1);
    chk(3, 32'h65, 32'h0, 32'h0, 1'b0);
    chk(3, 32'hFFFF_FFCE, 32'h0, 32'h0, 1'b1);
    chk(3, 32'hFFFF_FFCD, 32'h0, 32'h0, 1'b0);
    wr(2, pzc_pkg::PZC_FIELD_POS, 32'h7FFF_FFFF);
    wr(2, pzc_pkg::PZC_FIELD_NEG, 32'h8000_0000);
    chk(2, 32'h8000_0000, 32'h0, 32'h0, 1'b1);
    chk(2, 32'h7FFF_FFFF, 32'h0, 32'h0, 1'b1);
  endtask : t_abs
  // Offset 0x10 from target 0x100, width 8
  task automatic t_ofs();
    wr(5, pzc_pkg::PZC_FIELD_MODE, 32'h1);
    wr(5, pzc_pkg::PZC_FIELD_POS, 32'h10);
    wr(5, pzc_pkg::PZC_FIELD_NEG, 32'h8);
    chk(5, 32'h118, 32'h0, 32'h100, 1'b1);
    chk(5, 32'h119, 32'h0, 32'h100, 1'b0);
    chk(5, 32'h108, 32'h0, 32'h100, 1'b1);
    chk(5, 32'h107, 32'h0, 32'h100, 1'b0);
    chk(5, 32'h110, 32'h0, 32'h200, 1'b0);
  endtask : t_ofs
  task automatic t_src();
    wr(7, pzc_pkg::PZC_FIELD_SRC, 32'h1);
    chk(7, 32'h5, 32'h0, 32'h0, 1'b1);
    chk(7, 32'h0, 32'h1, 32'h0, 1'b0);
    wr(0, pzc_pkg::PZC_FIELD_SRC, 32'h0);
    chk(7, 32'h5, 32'h0, 32'h0, 1'b1);
  endtask : t_src
  // Zone 1 carries the checker: offset window, then reversed command limits
  task automatic t_zone1();
    wr(1, pzc_pkg::PZC_FIELD_MODE, 32'h1);
    wr(1, pzc_pkg::PZC_FIELD_POS, 32'h20);
    wr(1, pzc_pkg::PZC_FIELD_NEG, 32'h4);
    chk(1, 32'h120, 32'h0, 32'h100, 1'b1);
    chk(1, 32'h124, 32'h0, 32'h100, 1'b1);
    chk(1, 32'h125, 32'h0, 32'h100, 1'b0);
    chk(1, 32'h11B, 32'h0, 32'h100, 1'b0);
    wr(1, pzc_pkg::PZC_FIELD_MODE, 32'h0);
    wr(1, pzc_pkg::PZC_FIELD_SRC, 32'h1);
    wr(1, pzc_pkg::PZC_FIELD_POS, 32'hFFFF_FFFC);
    chk(1, 32'h50, 32'hFFFF_FFFC, 32'h0, 1'b1);
    chk(1, 32'h0, 32'h4, 32'h0, 1'b1);
    chk(1, 32'h0, 32'h5, 32'h0, 1'b0);
  endtask : t_zone1
  // Reset in mid-run returns every setting to zero
  task automatic t_rst2();
    @(negedge ref_clk);
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    chk(3, 32'h64, 32'h0, 32'h0, 1'b0);
    chk(5, 32'h0, 32'h0, 32'h100, 1'b1);
    chk(1, 32'h0, 32'h5, 32'h0, 1'b1);
  endtask : t_rst2
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // Watchdog: the tests need well under 1000 cycles
  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (5) @(negedge ref_clk);
    resetn = 1'b1;
    t_reset();
    t_abs();
    t_ofs();
    t_src();
    t_zone1();
    t_rst2();
    report_and_stop();
  end
endmodule : position_zone_comparators_tb
